// [common/port_b_pkg.sv]
package port_b_pkg;

  // ********************************************
  // Sizes and register offsets
  // ********************************************
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 8;
  localparam int NUM_PINS = 8;
  localparam int NUM_PAIR = 4;

  localparam logic [ADDR_W-1:0] OFF_INPUT  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_OUTPUT = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_DIR    = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_ODRAIN = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_PULLUP = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_ANALOG = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_FUNC   = 4'h6;

  // ********************************************
  // Function register fields and reset values
  // ********************************************
  localparam int F_PWM0   = 0;
  localparam int F_PWM1   = 1;
  localparam int F_CPUCK  = 2;
  localparam int F_XTALCK = 3;
  localparam int F_XTALEN = 4;
  localparam int F_USRT   = 5;
  localparam int F_UTX    = 6;
  localparam int F_URX    = 7;

  localparam logic [DATA_W-1:0]   RST_BYTE = 8'h00;
  localparam logic [NUM_PAIR-1:0] RST_ANA  = 4'h0;
  localparam logic [DATA_W-1:0]   UNMAPPED = 8'h00;

  // ********************************************
  // Carriers
  // ********************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull;
  } pin_drv_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] dir;
    logic [7:0] odrain;
    logic [7:0] pull;
    logic [3:0] ana;
    logic [7:0] func;
    logic [7:0] rdata;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pad_pull;
    logic [7:0] pad_ana;
    logic       cpu_div;
    logic       rx;
    logic [1:0] usrt_in;
  } state_t;

endpackage

// [hw/port_b_io.sv]
`timescale 1ns/100ps
module port_b_io
  import port_b_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst,
  // Register port
  input  wire reg_req_t      i_req,
  output logic [DATA_W-1:0]  o_rdata,
  // Pads
  input  wire logic [7:0]    i_pad_in,
  output logic [7:0]         o_pad_out,
  output logic [7:0]         o_pad_oe,
  output logic [7:0]         o_pad_pull,
  output logic [7:0]         o_pad_ibuf_en,
  output logic [7:0]         o_pad_analog,
  // Peripheral sources
  input  wire logic          i_pwm_out0,
  input  wire logic          i_pwm_out1,
  input  wire logic          i_xtal_clk,
  input  wire logic          i_serial_tx,
  input  wire logic          i_sync_serial_line0_value,
  input  wire logic          i_sync_serial_line1_value,
  input  wire logic          i_sync_serial_line0_drive,
  input  wire logic          i_sync_serial_line1_drive,
  // Peripheral sinks
  output logic               o_serial_rx,
  output logic [1:0]         o_sync_serial_in
);

  // ********************************************
  // Helpers
  // ********************************************

  // One analog bit covers two neighbouring pins
  function automatic logic [7:0] pair_mask(input logic [3:0] ana);
    logic [7:0] m;
    m = 8'h00;
    for (int k = 0; k < NUM_PINS; k++) begin
      m[k] = ana[k/2];
    end
    return m;
  endfunction

  // Pull-up is suppressed wherever the pad is actively driven
  function automatic pin_drv_t drive(input logic is_out, input logic od,
                                     input logic val, input logic req);
    pin_drv_t d;
    d.out  = val;
    d.oe   = is_out & (~od | ~val);
    d.pull = req & (~is_out | (od & val));
    return d;
  endfunction

  // ********************************************
  // State
  // ********************************************
  state_t st_r;
  state_t st_nxt;
  logic [7:0] ana_pins;

  assign ana_pins = pair_mask(st_r.ana);

  // Next state: register port, pin muxing
  always_comb begin
    pin_drv_t d;
    logic     is_out;
    logic     od;
    logic     val;
    d      = '0;
    is_out = 1'b0;
    od     = 1'b0;
    val    = 1'b0;
    st_nxt = st_r;

    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = 8'h00;
    if (i_req.rd) begin
      case (i_req.addr)
        OFF_INPUT:  st_nxt.rdata = i_pad_in & ~ana_pins;
        OFF_OUTPUT: st_nxt.rdata = st_r.out;
        OFF_DIR:    st_nxt.rdata = st_r.dir;
        OFF_ODRAIN: st_nxt.rdata = st_r.odrain;
        OFF_PULLUP: st_nxt.rdata = st_r.pull;
        OFF_ANALOG: st_nxt.rdata = {4'h0, st_r.ana};
        OFF_FUNC:   st_nxt.rdata = st_r.func;
        default:    st_nxt.rdata = UNMAPPED;
      endcase
    end

    // Writes land on the next edge
    if (i_req.wr) begin
      case (i_req.addr)
        OFF_OUTPUT: st_nxt.out    = i_req.wdata;
        OFF_DIR:    st_nxt.dir    = i_req.wdata;
        OFF_ODRAIN: st_nxt.odrain = i_req.wdata;
        OFF_PULLUP: st_nxt.pull   = i_req.wdata;
        OFF_ANALOG: st_nxt.ana    = i_req.wdata[3:0];
        OFF_FUNC:   st_nxt.func   = i_req.wdata;
        default:    st_nxt.out    = st_r.out;
      endcase
    end

    // Free-running divider gives an even duty clock on pin 2
    st_nxt.cpu_div = ~st_r.cpu_div;

    // Per-pin priority: analog, function, digital
    for (int i = 0; i < NUM_PINS; i++) begin
      is_out = st_r.dir[i];
      od     = st_r.odrain[i];
      val    = st_r.out[i];
      if (i == 0 && st_r.func[F_PWM0]) begin
        val = i_pwm_out0;
      end
      if (i == 1 && st_r.func[F_PWM1]) begin
        val = i_pwm_out1;
      end
      if (i == 2 && st_r.func[F_CPUCK]) begin
        val = st_r.cpu_div;
      end
      if (i == 3 && st_r.func[F_XTALCK] && st_r.func[F_XTALEN]) begin
        val = i_xtal_clk;
      end
      if (i == 4 && st_r.func[F_USRT]) begin
        is_out = i_sync_serial_line0_drive;
        od     = 1'b1;
        val    = i_sync_serial_line0_value;
      end
      if (i == 5 && st_r.func[F_USRT]) begin
        is_out = i_sync_serial_line1_drive;
        od     = 1'b1;
        val    = i_sync_serial_line1_value;
      end
      if (i == 6 && st_r.func[F_UTX]) begin
        is_out = 1'b1;
        od     = 1'b0;
        val    = i_serial_tx;
      end
      if (i == 7 && st_r.func[F_URX]) begin
        is_out = 1'b0;
      end
      d = drive(is_out, od, val, st_r.pull[i]);
      if (ana_pins[i]) begin
        d = '0;
      end
      st_nxt.pad_out[i]  = d.out & d.oe;
      st_nxt.pad_oe[i]   = d.oe;
      st_nxt.pad_pull[i] = d.pull;
    end
    st_nxt.pad_ana = ana_pins;

    // Idle-high feed when the pad is not lent to the peripheral
    st_nxt.rx = (st_r.func[F_URX] && !st_r.ana[3]) ? i_pad_in[7] : 1'b1;
    st_nxt.usrt_in[0] = (st_r.func[F_USRT] && !st_r.ana[2]) ? i_pad_in[4] : 1'b1;
    st_nxt.usrt_in[1] = (st_r.func[F_USRT] && !st_r.ana[2]) ? i_pad_in[5] : 1'b1;
  end

  // State register; every pad starts as an input
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_r         <= '0;
      st_r.out     <= RST_BYTE;
      st_r.dir     <= RST_BYTE;
      st_r.odrain  <= RST_BYTE;
      st_r.pull    <= RST_BYTE;
      st_r.ana     <= RST_ANA;
      st_r.rx      <= 1'b1;
      st_r.usrt_in <= 2'b11;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************************
  // Outputs
  // ********************************************

  // All from the state register, o_pad_ibuf_en through an inverter
  assign o_rdata          = st_r.rdata;
  assign o_pad_out        = st_r.pad_out;
  assign o_pad_oe         = st_r.pad_oe;
  assign o_pad_pull       = st_r.pad_pull;
  assign o_pad_ibuf_en    = ~st_r.pad_ana;
  assign o_pad_analog     = st_r.pad_ana;
  assign o_serial_rx      = st_r.rx;
  assign o_sync_serial_in = st_r.usrt_in;

  // ********************************************
  // Assertions
  // ********************************************

  a_pwm0_override: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_r.func[F_PWM0] && !st_r.ana[0] && st_r.dir[0] && !st_r.odrain[0]
    |=> o_pad_oe[0] && o_pad_out[0] == $past(i_pwm_out0))
    else $error("pwm0 not on pin 0");

  a_pwm1_dir_kept: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_r.func[F_PWM1] && !st_r.ana[0] && !st_r.dir[1] |=> !o_pad_oe[1])
    else $error("pwm1 forced pin direction");

  a_xtal_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_r.func[F_XTALCK] && st_r.func[F_XTALEN] && !st_r.ana[1] && st_r.dir[3]
    && !st_r.odrain[3] |=> o_pad_out[3] == $past(i_xtal_clk))
    else $error("crystal clock missing on pin 3");

  a_xtal_gated: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !st_r.func[F_XTALEN] && !st_r.ana[1] && st_r.dir[3] && !st_r.odrain[3]
    |=> o_pad_out[3] == $past(st_r.out[3]))
    else $error("pin 3 ignored output bit");

  a_cpu_clk_toggle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (st_r.func[F_CPUCK] && !st_r.ana[1] && st_r.dir[2] && !st_r.odrain[2])[*2]
    |=> o_pad_out[2] != $past(o_pad_out[2]))
    else $error("cpu clock on pin 2 not toggling");

  a_usrt_never_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_r.func[F_USRT] && !st_r.ana[2] |=> !(o_pad_oe[4] && o_pad_out[4]) && !(o_pad_oe[5] && o_pad_out[5]))
    else $error("usrt pin driven high");

  a_usrt_line_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_r.func[F_USRT] && !st_r.ana[2] && i_sync_serial_line1_drive && !i_sync_serial_line1_value
    |=> o_pad_oe[5] && !o_pad_out[5])
    else $error("usrt line 1 low not driven");

  a_uart_tx_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_r.func[F_UTX] && !st_r.ana[3] |=> o_pad_oe[6] && o_pad_out[6] == $past(i_serial_tx))
    else $error("uart tx not on pin 6");

  a_uart_rx_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_r.func[F_URX] && !st_r.ana[3] |=> !o_pad_oe[7] && o_serial_rx == $past(i_pad_in[7]))
    else $error("uart rx not fed from pin 7");

  a_push_pull_out: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_r.dir[6] && !st_r.odrain[6] && !st_r.func[F_UTX] && !st_r.ana[3]
    |=> o_pad_oe[6] && !o_pad_pull[6] && o_pad_out[6] == $past(st_r.out[6]))
    else $error("push-pull pin 6 wrong");

  a_open_drain_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_r.dir[7] && st_r.odrain[7] && st_r.out[7] && !st_r.func[F_URX] && !st_r.ana[3]
    |=> !o_pad_oe[7] && o_pad_pull[7] == $past(st_r.pull[7]))
    else $error("open-drain high pin 7 wrong");

  a_input_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_req.rd && i_req.addr == OFF_INPUT && st_r.ana == 4'h0 |=> o_rdata == $past(i_pad_in))
    else $error("input read not direct");

  a_analog_pair: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_r.ana[2] |=> o_pad_oe[5:4] == 2'b00 && o_pad_ibuf_en[5:4] == 2'b00 && o_pad_pull[5:4] == 2'b00)
    else $error("analog pair still digital");

  a_dir_readback: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_req.wr && i_req.addr == OFF_DIR ##1 i_req.rd && i_req.addr == OFF_DIR
    |=> o_rdata == $past(i_req.wdata, 2))
    else $error("direction readback wrong");

  a_reset_input: assert property (@(posedge i_clk_sys)
    $fell(i_rst) |-> st_r.dir == 8'h00 && st_r.pull == 8'h00 && o_pad_oe == 8'h00)
    else $error("pins not inputs after reset");

endmodule

// [tb/port_b_pads.sv]
`timescale 1ns/100ps
// ****
// Pads and board seen from outside the port
// ****
module port_b_pads (
  // Clock
  input  wire logic       i_clk_sys,
  // Port drive
  input  wire logic [7:0] i_pad_out,
  input  wire logic [7:0] i_pad_oe,
  input  wire logic [7:0] i_pad_pull,
  // Board drivers
  input  wire logic [7:0] i_ext_en,
  input  wire logic [7:0] i_ext_val,
  // Resolved levels
  output logic [7:0]      o_level
);
  logic [7:0] last_r = 8'h00;

  // Floating pins flip every cycle so a stale value never passes
  always_ff @(posedge i_clk_sys) last_r <= o_level;

  // Contention resolves to the port driver; not electrically faithful
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      o_level[i] = i_pad_oe[i] ? i_pad_out[i] : i_ext_en[i] ? i_ext_val[i] : i_pad_pull[i] ? 1'b1 : ~last_r[i];
    end
  end
endmodule

// [tb/port_b_io_tb_top.sv]
`timescale 1ns/100ps
module port_b_io_tb_top;
  import port_b_pkg::*;
  // ****
  // Signals and model state
  // ****
  logic       i_clk_sys, i_rst, rx;
  reg_req_t   req;
  logic [7:0] rdata, pad_out, pad_oe, pad_pull, ibuf, ana, lvl, ext_en, ext_val, periph;
  logic [7:0] m_out, m_dir, m_od, m_pu, m_fn;
  logic [3:0] m_ana;
  logic [1:0] usrt_in;
  int         num_errors = 0, samples_checked = 0, seed = 70877, cnt;

  port_b_io dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(req), .o_rdata(rdata), .i_pad_in(lvl),
    .o_pad_out(pad_out), .o_pad_oe(pad_oe), .o_pad_pull(pad_pull), .o_pad_ibuf_en(ibuf), .o_pad_analog(ana),
    .i_pwm_out0(periph[0]), .i_pwm_out1(periph[1]), .i_xtal_clk(periph[2]), .i_serial_tx(periph[3]),
    .i_sync_serial_line0_value(periph[4]), .i_sync_serial_line1_value(periph[5]),
    .i_sync_serial_line0_drive(periph[6]), .i_sync_serial_line1_drive(periph[7]),
    .o_serial_rx(rx), .o_sync_serial_in(usrt_in));
  port_b_pads pads (.i_clk_sys(i_clk_sys), .i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_pad_pull(pad_pull),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(lvl));

  // ****
  // Tasks
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Writes to offset 0 and unmapped places leave the model alone
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys) req.wr <= 1'b0;
    case (a)
      4'h1: m_out = d;
      4'h2: m_dir = d;
      4'h3: m_od = d;
      4'h4: m_pu = d;
      4'h5: m_ana = d[3:0];
      4'h6: m_fn = d;
      default: ;
    endcase
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk_sys) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys) req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Overrides fold into direction, drain mode and value per pin
  function automatic void exp_pins(output logic [7:0] eoe, eout, epu);
    logic d, od, v;
    for (int i = 0; i < 8; i++) begin
      d = m_dir[i];
      od = m_od[i];
      v = m_out[i];
      if (i < 2 && m_fn[i]) v = periph[i];
      if (i == 3 && m_fn[F_XTALCK] && m_fn[F_XTALEN]) v = periph[2];
      if ((i == 4 || i == 5) && m_fn[F_USRT]) begin
        d = 1'b1;
        od = 1'b1;
        v = ~periph[i + 2] | periph[i];
      end
      if (i == 6 && m_fn[F_UTX]) begin
        {d, od, v} = {2'b10, periph[3]};
      end
      if (i == 7 && m_fn[F_URX]) d = 1'b0;
      eoe[i] = d & ~(od & v);
      eout[i] = d & ~od & v;
      epu[i] = m_pu[i] & ~eoe[i] & ~(d & ~od);
      if (m_ana[i / 2]) {eoe[i], eout[i], epu[i]} = 3'h0;
    end
  endfunction

  task automatic check_all();
    logic [7:0] eoe, eout, epu, am, kn, lk, el, d, se, sk;
    logic u, r;
    exp_pins(eoe, eout, epu);
    for (int i = 0; i < 8; i++) am[i] = m_ana[i / 2];
    kn = m_fn[F_CPUCK] ? 8'hfb : 8'hff;
    lk = kn & (eoe | ext_en | epu);
    el = (eoe & eout) | (~eoe & ext_en & ext_val) | (~eoe & ~ext_en & epu);
    u = m_fn[F_USRT] & ~m_ana[2];
    r = m_fn[F_URX] & ~m_ana[3];
    se = {5'h00, u ? el[5:4] : 2'b11, r ? el[7] : 1'b1};
    sk = {5'h00, u ? lk[5:4] : 2'b11, r ? lk[7] : 1'b1};
    check(pad_oe & kn, eoe & kn);
    check(pad_out & kn, eout & kn);
    check(pad_pull & kn, epu & kn);
    check(ibuf, ~am);
    check(ana, am);
    check({5'h00, usrt_in, rx} & sk, se & sk);
    for (int a = 1; a < 7; a++) begin
      rd(4'(a), d);
      check(d, a == 1 ? m_out : a == 2 ? m_dir : a == 3 ? m_od : a == 4 ? m_pu : a == 5 ? {4'h0, m_ana} : m_fn);
    end
    rd(OFF_INPUT, d);
    check(d & (lk | am), el & ~am & lk);
    rd(4'(7 + $unsigned($random(seed)) % 9), d);
    check(d, UNMAPPED);
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****
  // Clock, watchdog and sequence
  // ****
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  // Whole run is near 2500 cycles; this cuts a hang
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end

  initial begin
    logic [7:0] eoe, eout, epu, v;
    i_rst = 1'b1;
    req = '0;
    {periph, ext_en, ext_val} = '0;
    {m_out, m_dir, m_od, m_pu, m_fn, m_ana} = '0;
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys) #1 check_all();
    // Random setups, board drive only where the model expects no port drive
    for (int n = 0; n < 60; n++) begin
      for (int a = 0; a < 8; a++) wr(4'(a), 8'($random(seed)));
      if (n[0]) wr(OFF_DIR, m_dir | (m_fn & 8'h0f));
      if (m_fn[F_USRT]) wr(OFF_PULLUP, m_pu | 8'h30);
      @(posedge i_clk_sys) periph <= 8'($random(seed));
      @(posedge i_clk_sys) exp_pins(eoe, eout, epu);
      ext_en <= 8'($random(seed)) & ~eoe;
      ext_val <= 8'($random(seed));
      repeat (3) @(posedge i_clk_sys);
      #1 check_all();
    end
    // Write then read back with no gap between strobes; read data stand one cycle
    v = 8'($random(seed));
    @(posedge i_clk_sys) req <= '{addr: OFF_DIR, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys) req <= '{addr: OFF_DIR, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    m_dir = v;
    @(posedge i_clk_sys) req.rd <= 1'b0;
    #1 check(rdata, m_dir);
    @(posedge i_clk_sys) #1 check(rdata, 8'h00);
    // Clock outputs on pins 2 and 3
    wr(OFF_ANALOG, 8'h00);
    wr(OFF_ODRAIN, 8'h00);
    wr(OFF_DIR, 8'h0c);
    wr(OFF_FUNC, 8'h1c);
    periph <= 8'h00;
    repeat (3) @(posedge i_clk_sys);
    #1 v = pad_out;
    cnt = 0;
    for (int k = 0; k < 64; k++) begin
      @(posedge i_clk_sys) periph[2] <= ~k[2];
      #1 check({7'h00, pad_out[2]}, {7'h00, ~v[2]});
      v = pad_out;
      cnt += pad_out[3];
    end
    check(8'(cnt), 8'h20);
    // Second reset in mid-run
    @(posedge i_clk_sys) i_rst <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    {m_out, m_dir, m_od, m_pu, m_fn, m_ana} = '0;
    @(posedge i_clk_sys) #1 check_all();
    print_verdict();
  end
endmodule
